// >>> host_link_cfg.svh
// Purpose: Constants for the host strap, hibernate and serial slave control block.
// Assumes: System clock of 125 MHz; serial bytes are eight bits, most significant first.
// Notes:   Timing figures are kept in their own unit and converted where they are used.
`ifndef HOST_LINK_CFG_SVH
`define HOST_LINK_CFG_SVH

// System clock and wake-up initialisation time.
`define SYS_CLK_HZ          64'd125000000
`define WAKE_INIT_TIME_MS   64'd40
`define MS_PER_S            64'd1000
`define WAKE_CNT_W          23

// Cycles the strap levels must stay stable after the synchronisers before they are latched.
`define STRAP_SETTLE_CYCLES 3'h4
`define STRAP_CNT_W         3

// Strap levels that select normal operation.
`define STRAP_LOW_NORMAL    1'b0
`define STRAP_SHARED_NORMAL 1'b1

// Synchroniser lanes in the system domain.
`define SYNC_W              4
`define SYNC_HIB            0
`define SYNC_STRAP_LOW      1
`define SYNC_SHARED         2
`define SYNC_RX_TOGGLE      3

// Serial byte shape.
`define SPI_BYTE_W          8
`define SPI_BIT_CNT_W       3
`define SPI_LAST_BIT        3'h7

// Reset values.
`define BYTE_RESET          8'h00

`endif

// >>> host_link_pkg.sv
// Purpose: Types shared by the host strap, hibernate and serial slave control block.
// Assumes: The constants header is compiled alongside this package.
// Notes:   The system-domain state is one packed struct, registered as a whole.
`include "host_link_cfg.svh"

package host_link_pkg;

  typedef enum logic [4:0] {
    ST_OFF    = 5'h01,
    ST_SAMPLE = 5'h02,
    ST_INIT   = 5'h04,
    ST_RUN    = 5'h08,
    ST_HALT   = 5'h10
  } power_state_t;

  typedef struct packed {
    logic boot_strap_low_pin;
    logic select_strap_shared_pin;
  } straps_t;

  typedef struct packed {
    logic [`SPI_BYTE_W-1:0] data;
    logic                   valid;
  } rx_beat_t;

  typedef struct packed {
    power_state_t           state;
    logic [`SYNC_W-1:0]     sync1;
    logic [`SYNC_W-1:0]     sync2;
    logic                   toggle_seen;
    logic [`STRAP_CNT_W-1:0] settle_cnt;
    logic [`WAKE_CNT_W-1:0] wake_cnt;
    straps_t                straps;
    logic                   link_open;
    rx_beat_t               rx;
    logic [`SPI_BYTE_W-1:0] tx_hold;
    logic                   host_int_n;
  } sys_state_t;

  typedef struct packed {
    logic [`SPI_BYTE_W-2:0]   shift;
    logic [`SPI_BIT_CNT_W-1:0] bit_cnt;
  } spi_frame_t;

endpackage

// >>> spi_slave_shifter.sv
// Purpose: Serial slave shifter clocked by the host's serial clock.
// Assumes: Mode 0: data in is sampled on the rising edge, data out changes after it.
// Notes:   The bit counter is cleared while select is high, since the clock stands still
//          between frames and no edge can be counted on to end a frame.
`timescale 1ns/1ps
`include "host_link_cfg.svh"

module spi_slave_shifter (
  // Link clock and select
  input  wire logic                   i_spi_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_select_n,
  // Serial data
  input  wire logic                   i_spi_mosi,
  output logic                        o_spi_miso,
  // Byte exchange with the system domain
  input  wire logic [`SPI_BYTE_W-1:0] i_tx_byte,
  output logic [`SPI_BYTE_W-1:0]      o_rx_byte,
  output logic                        o_rx_toggle
);

  host_link_pkg::spi_frame_t frame;
  host_link_pkg::spi_frame_t next_frame;

  always_comb begin
    next_frame         = frame;
    next_frame.shift   = {frame.shift[`SPI_BYTE_W-3:0], i_spi_mosi};
    next_frame.bit_cnt = frame.bit_cnt + 3'h1;
  end

  // Select high clears the frame with a constant; it is the only end a frame has.
  always_ff @(posedge i_spi_clk or posedge i_select_n) begin
    if (i_select_n) begin
      frame <= '0;
    end else begin
      frame <= next_frame;
    end
  end

  // The completed byte and its toggle survive the frame so the system side can collect them.
  always_ff @(posedge i_spi_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_byte   <= `BYTE_RESET;
      o_rx_toggle <= 1'b0;
    end else if (frame.bit_cnt == `SPI_LAST_BIT) begin
      o_rx_byte   <= {frame.shift, i_spi_mosi};
      o_rx_toggle <= ~o_rx_toggle;
    end
  end

  // The reply byte is stable for the whole frame, so a plain bit select is safe here.
  assign o_spi_miso = i_tx_byte[`SPI_LAST_BIT - frame.bit_cnt];
endmodule

// >>> host_link_ctrl.sv
// Purpose: Host-facing control of the wireless module: straps, hibernate, interrupt, serial.
// Assumes: Serial select and data are timed to the serial clock by the host.
// Notes:   The 40 ms wake-up count is a parameter so that a simulation can shorten it.
`timescale 1ns/1ps
`include "host_link_cfg.svh"

//////////////////////////////////////////////////////////////////////////////////////////////

// What this block does
// - Latch both straps at power-on and wake.
// - After start, shared strap becomes active-low select.
// - Four-wire serial slave; host is master.
// - Interrupt event shown by driving output low.
// - Hibernate low enters lowest power state.
// - Hibernation discards system-side state; shifter keeps last byte.
// - Wake-up initialisation takes about 40 ms.
// - Clock, data in are inputs; data out output.
module host_link_ctrl #(
  parameter int unsigned WAKE_CYCLES =
    int'((`WAKE_INIT_TIME_MS * `SYS_CLK_HZ) / `MS_PER_S)
) (
  // System clock and reset
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst,
  // Strap and hibernate pins
  input  wire logic                      i_boot_strap_low_pin,
  input  wire logic                      i_select_strap_shared_pin,
  input  wire logic                      i_hibernate_n,
  // Serial link pins
  input  wire logic                      i_spi_clk,
  input  wire logic                      i_spi_mosi,
  output logic                           o_spi_miso,
  output logic                           o_spi_miso_oe,
  // Interrupt pin
  output logic                           o_host_int_n,
  // Module core side
  input  wire logic                      i_event_pending,
  input  wire logic [`SPI_BYTE_W-1:0]    i_tx_data,
  input  wire logic                      i_tx_valid,
  output logic                           o_tx_ready,
  output host_link_pkg::rx_beat_t        o_rx,
  output host_link_pkg::straps_t         o_straps,
  output logic                           o_normal_mode,
  output logic                           o_core_run,
  output logic                           o_low_power
);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Constants and state.

  localparam logic [`WAKE_CNT_W-1:0] WAKE_LAST = `WAKE_CNT_W'(WAKE_CYCLES - 1);

  host_link_pkg::sys_state_t st;
  host_link_pkg::sys_state_t next_st;

  logic [`SPI_BYTE_W-1:0] rx_byte_link;
  logic                   rx_toggle_link;
  logic [`SYNC_W-1:0]     pin_bus;
  logic                   hib_req;
  logic                   select_idle;
  logic                   rx_event;
  logic                   straps_normal;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Link-clock shifter.

  spi_slave_shifter u_shifter (
    .i_spi_clk   (i_spi_clk),
    .i_rst       (i_rst),
    .i_select_n  (i_select_strap_shared_pin),
    .i_spi_mosi  (i_spi_mosi),
    .o_spi_miso  (o_spi_miso),
    .i_tx_byte   (st.tx_hold),
    .o_rx_byte   (rx_byte_link),
    .o_rx_toggle (rx_toggle_link)
  );

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Decoded views of the synchronised inputs.

  always_comb begin
    pin_bus                  = '0;
    pin_bus[`SYNC_HIB]       = i_hibernate_n;
    pin_bus[`SYNC_STRAP_LOW] = i_boot_strap_low_pin;
    pin_bus[`SYNC_SHARED]    = i_select_strap_shared_pin;
    pin_bus[`SYNC_RX_TOGGLE] = rx_toggle_link;
  end

  assign hib_req       = ~st.sync2[`SYNC_HIB];
  assign select_idle   = st.sync2[`SYNC_SHARED];
  assign rx_event      = st.sync2[`SYNC_RX_TOGGLE] != st.toggle_seen;
  assign straps_normal = (st.straps.boot_strap_low_pin == `STRAP_LOW_NORMAL) &&
                         (st.straps.select_strap_shared_pin == `STRAP_SHARED_NORMAL);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    next_st          = st;
    next_st.sync1    = pin_bus;
    next_st.sync2    = st.sync1;
    next_st.rx.valid = 1'b0;
    next_st.toggle_seen = st.sync2[`SYNC_RX_TOGGLE];

    unique case (st.state)
      host_link_pkg::ST_OFF: begin
        // Everything learned before sleep is dropped here, not merely hidden.
        next_st.straps     = '0;
        next_st.tx_hold    = `BYTE_RESET;
        next_st.rx.data    = `BYTE_RESET;
        next_st.link_open  = 1'b0;
        next_st.host_int_n = 1'b1;
        next_st.settle_cnt = '0;
        next_st.wake_cnt   = '0;
        if (!hib_req) begin
          next_st.state = host_link_pkg::ST_SAMPLE;
        end
      end

      host_link_pkg::ST_SAMPLE: begin
        // The pins have just left the synchronisers; let them settle before latching.
        next_st.settle_cnt = st.settle_cnt + 3'h1;
        if (hib_req) begin
          next_st.state = host_link_pkg::ST_OFF;
        end else if (st.settle_cnt == `STRAP_SETTLE_CYCLES) begin
          next_st.straps.boot_strap_low_pin      = st.sync2[`SYNC_STRAP_LOW];
          next_st.straps.select_strap_shared_pin = st.sync2[`SYNC_SHARED];
          next_st.state                          = host_link_pkg::ST_INIT;
        end
      end

      host_link_pkg::ST_INIT: begin
        next_st.wake_cnt = st.wake_cnt + `WAKE_CNT_W'(1);
        if (hib_req) begin
          next_st.state = host_link_pkg::ST_OFF;
        end else if (st.wake_cnt == WAKE_LAST) begin
          // Straps other than the normal pair choose the halted mode; the link stays shut.
          next_st.state = straps_normal ? host_link_pkg::ST_RUN
                                        : host_link_pkg::ST_HALT;
        end
      end

      host_link_pkg::ST_RUN: begin
        next_st.link_open  = 1'b1;
        next_st.host_int_n = ~i_event_pending;
        // The byte stays put for eight serial clocks, far longer than the toggle takes
        // through its two stages. A byte seen as hibernate arrives is dropped with the rest.
        if (rx_event && st.link_open && !hib_req) begin
          next_st.rx.data  = rx_byte_link;
          next_st.rx.valid = 1'b1;
        end
        if (i_tx_valid && select_idle && st.link_open) begin
          next_st.tx_hold = i_tx_data;
        end
        if (hib_req) begin
          next_st.state      = host_link_pkg::ST_OFF;
          next_st.link_open  = 1'b0;
          next_st.host_int_n = 1'b1;
        end
      end

      host_link_pkg::ST_HALT: begin
        next_st.host_int_n = 1'b1;
        if (hib_req) begin
          next_st.state = host_link_pkg::ST_OFF;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st            <= '0;
      st.state      <= host_link_pkg::ST_OFF;
      st.sync1      <= {`SYNC_W{1'b0}};
      st.sync2      <= {`SYNC_W{1'b0}};
      st.host_int_n <= 1'b1;
      st.tx_hold    <= `BYTE_RESET;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Data out is driven only inside a frame while the link is open; otherwise the board
  // pull-down holds the line low.
  assign o_spi_miso_oe = st.link_open & ~i_select_strap_shared_pin;
  assign o_host_int_n  = st.host_int_n;
  assign o_tx_ready    = st.link_open & select_idle;
  assign o_straps      = st.straps;
  assign o_normal_mode = straps_normal;
  assign o_core_run    = st.state == host_link_pkg::ST_RUN;
  assign o_low_power   = st.state == host_link_pkg::ST_OFF;

  // The received byte and its valid leave the state register together.
  always_comb begin
    o_rx       = '0;
    o_rx.data  = st.rx.data;
    o_rx.valid = st.rx.valid;
  end

endmodule

// >>> host_link_monitor.sv
// Purpose: Port-level checks on the host link control block.
// Assumes: All checked signals but i_hibernate_n and o_spi_miso_oe belong to the system clock domain.
// Notes:   Wake timing follows the WAKE_CYCLES value handed to the design.
`timescale 1ns/1ps

module host_link_monitor #(
  parameter int unsigned WAKE_CYCLES = 50
) (
  // Clock, reset and pins
  input wire logic                   i_clk_sys,
  input wire logic                   i_rst,
  input wire logic                   i_hibernate_n,
  input wire logic                   i_event_pending,
  // Outputs watched
  input wire logic                   o_spi_miso_oe,
  input wire logic                   o_host_int_n,
  input wire logic                   o_tx_ready,
  input wire host_link_pkg::rx_beat_t o_rx,
  input wire host_link_pkg::straps_t  o_straps,
  input wire logic                   o_normal_mode,
  input wire logic                   o_core_run,
  input wire logic                   o_low_power
);
  localparam int LO = WAKE_CYCLES - 3;
  localparam int HI = WAKE_CYCLES + 1;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_int_idle_high: assert property (!o_core_run && !$past(o_core_run) |-> o_host_int_n)
    else $error("interrupt low outside run");
  a_int_event: assert property (o_core_run && $past(o_core_run) |->
    o_host_int_n == !$past(i_event_pending))
    else $error("interrupt does not follow event");
  a_hib_enter: assert property (!i_hibernate_n [*3] |=> o_low_power)
    else $error("hibernate not entered");
  a_hib_clear: assert property (o_low_power && $past(o_low_power) |->
    o_straps == 2'b00 && !o_core_run && !o_rx.valid)
    else $error("state kept in hibernate");
  a_link_closed: assert property (o_spi_miso_oe || o_tx_ready |-> o_core_run)
    else $error("link open outside run");
  a_rx_once: assert property (o_rx.valid |-> o_core_run ##1 !o_rx.valid)
    else $error("bad receive pulse");
  a_strap_latch: assert property ($rose(o_core_run) |->
    o_normal_mode && o_straps == 2'b01)
    else $error("run without normal straps");
  a_strap_hold: assert property (o_core_run && $past(o_core_run) |-> $stable(o_straps))
    else $error("straps changed in run");
  a_wake_early: assert property ($fell(o_low_power) |-> !o_core_run [*8])
    else $error("run too early");
  a_wake_time: assert property ($fell(o_low_power) ##6 o_normal_mode |->
    ##[LO:HI] o_core_run)
    else $error("run not reached in time");
endmodule

// >>> host_mcu_model.sv
// Purpose: Host side of the strap, hibernate and serial pins.
// Assumes: Serial mode 0, MSB first, 48 ns clock that runs only inside frames.
// Notes:   Data in is inverted after a frame so a stale level is never trusted.
`timescale 1ns/1ps

module host_mcu_model (
  // Pins toward the module
  output logic      o_spi_clk,
  output logic      o_select_n,
  output logic      o_spi_mosi,
  output logic      o_hibernate_n,
  output logic      o_boot_strap,
  // Pin read back
  input  wire logic i_spi_miso
);
  initial begin
    o_spi_clk = 1'b0;
    o_select_n = 1'b1;
    o_spi_mosi = 1'b0;
    o_hibernate_n = 1'b0;
    o_boot_strap = 1'b0;
  end

  task automatic set_pins(input logic hib_n, input logic strap);
    o_boot_strap <= strap;
    o_hibernate_n <= hib_n;
  endtask

  task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    o_select_n <= 1'b0;
    #20;
    for (int i = n - 1; i >= 0; i--) begin
      o_spi_mosi <= tx[i];
      #24;
      rx[i] = i_spi_miso;
      o_spi_clk <= 1'b1;
      #24;
      o_spi_clk <= 1'b0;
    end
    #20;
    o_select_n <= 1'b1;
    o_spi_mosi <= ~o_spi_mosi;
    // Keep select high for a full serial period so back-to-back frames stay apart.
    #48;
  endtask
endmodule

// >>> host_link_ctrl_tb.sv
// Purpose: Self-checking bench for the host link control block.
// Assumes: 125 MHz system clock; wake count shortened to W cycles.
// Notes:   Received bytes are collected in a queue by a free-running sampler.
`timescale 1ns/1ps

module host_link_ctrl_tb;
  localparam int unsigned W = 50;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    sclk, sel_n, mosi, hib_n, strap, miso, oe, miso_pin, int_n;
  logic                    ev = 1'b0;
  logic [7:0]              tx_d = 8'h00;
  logic                    tx_v = 1'b0;
  logic                    rdy, normal, run, lowp;
  host_link_pkg::rx_beat_t rx;
  host_link_pkg::straps_t  straps;
  int                      mismatches = 0;
  int                      n_tests = 0;
  logic [7:0]              rxq[$];
  logic [15:0]             got;

  always #4 clk = ~clk;
  // The board pull-down holds data out low whenever the module lets go of it.
  assign miso_pin = oe ? miso : 1'b0;
  always @(negedge clk) if (rx.valid === 1'b1) rxq.push_back(rx.data);

  host_link_ctrl #(.WAKE_CYCLES(W)) u_host_link_ctrl (.i_clk_sys(clk), .i_rst(rst),
    .i_boot_strap_low_pin(strap), .i_select_strap_shared_pin(sel_n), .i_hibernate_n(hib_n),
    .i_spi_clk(sclk), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(oe),
    .o_host_int_n(int_n), .i_event_pending(ev), .i_tx_data(tx_d), .i_tx_valid(tx_v),
    .o_tx_ready(rdy), .o_rx(rx), .o_straps(straps), .o_normal_mode(normal),
    .o_core_run(run), .o_low_power(lowp));
  host_mcu_model u_host_mcu_model (.o_spi_clk(sclk), .o_select_n(sel_n), .o_spi_mosi(mosi),
    .o_hibernate_n(hib_n), .o_boot_strap(strap), .i_spi_miso(miso_pin));

  ////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic conclude;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wake(input logic s, output int n);
    n = 0;
    @(posedge clk);
    u_host_mcu_model.set_pins(1'b1, s);
    while (run !== 1'b1 && n < W + 40) begin
      @(negedge clk);
      n++;
    end
    if (s == 1'b0 && n >= W + 40) begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic t_wake_ok;
    int n;
    wake(1'b0, n);
    chkb(n >= W + 5 && n <= W + 11, 1'b1);
    @(negedge clk);
    chk({14'h0000, straps}, 16'h0001);
    chkb(normal, 1'b1);
  endtask
  task automatic t_bad_strap;
    int n;
    wake(1'b1, n);
    chkb(run, 1'b0);
    chk({14'h0000, straps}, 16'h0003);
  endtask
  task automatic t_int;
    @(posedge clk);
    ev <= 1'b1;
    repeat (2) @(negedge clk);
    chkb(int_n, 1'b0);
    @(posedge clk);
    ev <= 1'b0;
    repeat (2) @(negedge clk);
    chkb(int_n, 1'b1);
    chkb(rdy, 1'b1);
  endtask
  task automatic t_rx;
    @(posedge clk);
    tx_d <= 8'ha5;
    tx_v <= 1'b1;
    @(posedge clk);
    tx_v <= 1'b0;
    rxq.delete();
    u_host_mcu_model.frame(16'h3c96, 16, got);
    chk(got, 16'ha5a5);
    u_host_mcu_model.frame(16'h000f, 4, got);
    repeat (10) @(posedge clk);
    chk(16'(rxq.size()), 16'h0002);
    chk({rxq[0], rxq[1]}, 16'h3c96);
  endtask
  task automatic t_hib;
    @(posedge clk);
    ev <= 1'b1;
    u_host_mcu_model.set_pins(1'b0, 1'b0);
    repeat (5) @(negedge clk);
    chkb(lowp, 1'b1);
    chkb(int_n, 1'b1);
    chkb(rdy, 1'b0);
    chk({14'h0000, straps}, 16'h0000);
    rxq.delete();
    u_host_mcu_model.frame(16'h00ff, 8, got);
    chk(got, 16'h0000);
    repeat (10) @(posedge clk);
    chk(16'(rxq.size()), 16'h0000);
    ev <= 1'b0;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_wake_ok();
    t_int();
    t_rx();
    t_hib();
    t_bad_strap();
    t_hib();
    t_wake_ok();
    t_rx();
    conclude();
  end
endmodule

bind host_link_ctrl host_link_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) u_host_link_monitor (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_hibernate_n(i_hibernate_n),
  .i_event_pending(i_event_pending), .o_spi_miso_oe(o_spi_miso_oe),
  .o_host_int_n(o_host_int_n), .o_tx_ready(o_tx_ready), .o_rx(o_rx), .o_straps(o_straps),
  .o_normal_mode(o_normal_mode), .o_core_run(o_core_run), .o_low_power(o_low_power));
